//--- logic/ring_pkg.sv
package ring_pkg;

  // ==========================================================
  // endpoint geometry
  localparam int EP_COUNT = 8;
  localparam logic [3:0] EP_FIRST = 4'h4;
  localparam logic [3:0] EP_LAST = 4'hB;
  localparam int ADDR_W = 18;
  localparam int PTR_W = 16;
  localparam int DATA_W = 16;
  localparam int REG_W = 18;
  localparam int FIFO_DEPTH = 4;

  // ==========================================================
  // register index: {slot[2:0], field[2:0]}
  localparam logic [2:0] F_DESC = 3'h0;
  localparam logic [2:0] F_BASE = 3'h1;
  localparam logic [2:0] F_SIZE = 3'h2;
  localparam logic [2:0] F_RDOFF = 3'h3;
  localparam logic [2:0] F_WROFF = 3'h4;
  localparam logic [2:0] F_POLICY = 3'h5;
  localparam logic [2:0] F_CTRL = 3'h6;
  localparam logic [2:0] F_STAT = 3'h7;
  localparam logic [4:0] SETUP_ALL = 5'h1F;

  // ==========================================================
  // field layouts
  localparam int DESC_DIR_BIT = 0;
  localparam int DESC_MPS_LSB = 3;
  localparam int DESC_MPS_W = 10;
  localparam int NAK_LIMIT_W = 4;
  localparam int CTRL_RECONNECT_BIT = 0;

  // ==========================================================
  // timing
  localparam int CLK_MHZ = 50;
  localparam int DETACH_US = 10;
  localparam int DETACH_CYC = DETACH_US * CLK_MHZ;

  // ==========================================================
  // carriers and states
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } mem_word_s;

  typedef enum logic [9:0] {
    ST_IDLE      = 10'h001,
    ST_LOAD      = 10'h002,
    ST_DECIDE    = 10'h004,
    ST_OUT_RX    = 10'h008,
    ST_OUT_DRAIN = 10'h010,
    ST_WBACK     = 10'h020,
    ST_IN_RD     = 10'h040,
    ST_IN_LO     = 10'h080,
    ST_IN_HI     = 10'h100,
    ST_IN_WAIT   = 10'h200
  } eng_e;

endpackage : ring_pkg

//--- logic/ep_store.sv
`timescale 1ns/1ps
module ep_store #(
  parameter int WIDTH = 18,
  parameter int AW    = 6
) (
  // clock
  input  wire logic             clock,
  // write port
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  // read port, data one cycle later
  input  wire logic             rd_en,
  input  wire logic [AW-1:0]    rd_addr,
  output logic      [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem [0:(1<<AW)-1];

  // no reset: the setup mask guards unwritten words except the policy field
  always_ff @(posedge clock) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule : ep_store

//--- logic/word_fifo.sv
`timescale 1ns/1ps
module word_fifo #(
  parameter int WIDTH = 34,
  parameter int DEPTH = 4
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             rst,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [PW:0]   count;
  } fifo_s;

  fifo_s s, n;
  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic push, pop;

  assign in_ready = (s.count != (PW+1)'(DEPTH));
  assign out_valid = (s.count != '0);
  assign out_data = mem[s.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    bump = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : bump

  always_comb begin
    n = s;
    if (push) begin
      n.wp = bump(s.wp);
    end
    if (pop) begin
      n.rp = bump(s.rp);
    end
    n.count = s.count + (PW+1)'(push) - (PW+1)'(pop);
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= n;
    end
    if (push) begin
      mem[s.wp] <= in_data;
    end
  end
endmodule : word_fifo

//--- logic/ring_engine.sv
// Overview of operation
// - first attach exposes only the control endpoint
// - control register write detaches then reattaches device
// - endpoint idle until all five setup registers written
// - this engine alone serves endpoints four to eleven
// - 18-bit base plus 16-bit size and offsets
// - only whole words reach memory, odd byte dropped
// - endpoint zero keeps byte transfers, not handled here
// - OUT core owns write pointer, IN read pointer
// - both pointers start at the offsets software writes at setup
// - buffers are circular, owner wraps its pointer
// - OUT room comes from write and read difference
// - whole packet stored means ACK, write offset updated
// - collision means NAK, write pointer left unchanged
// - oversize OUT packet accepted when room allows
// - IN sends full packet, advances read on ACK
// - short IN data NAKed a programmed count first
`timescale 1ns/1ps
module ring_engine import ring_pkg::*; #(
  parameter int DEPTH = FIFO_DEPTH
) (
  // clock and reset
  input  wire logic              clock,
  input  wire logic              rst,
  // dsp register port
  input  wire logic              reg_req,
  input  wire logic              reg_we,
  input  wire logic [5:0]        reg_addr,
  input  wire logic [REG_W-1:0]  reg_wdata,
  output logic                   reg_ack_r,
  output logic      [REG_W-1:0]  reg_rdata_r,
  // bus attachment
  output logic                   attach_r,
  output logic                   config_only_r,
  // token from the serial engine
  input  wire logic              tok_valid,
  input  wire logic [3:0]        tok_ep,
  input  wire logic              tok_in,
  output logic                   tok_ready_r,
  // OUT byte stream
  input  wire logic              rx_valid,
  input  wire logic [7:0]        rx_byte,
  input  wire logic              rx_last,
  output logic                   rx_ready_r,
  // IN byte stream
  output logic                   tx_valid_r,
  output logic      [7:0]        tx_byte_r,
  output logic                   tx_last_r,
  output logic                   tx_empty_r,
  input  wire logic              tx_ready,
  // handshakes
  output logic                   hs_ack_r,
  output logic                   hs_nak_r,
  input  wire logic              in_hs_valid,
  input  wire logic              in_hs_ack,
  // dsp memory
  output logic                   mem_req_r,
  output logic                   mem_we_r,
  output logic      [ADDR_W-1:0] mem_addr_r,
  output logic      [DATA_W-1:0] mem_wdata_r,
  input  wire logic              mem_gnt,
  input  wire logic              mem_rvalid,
  input  wire logic [DATA_W-1:0] mem_rdata
);
  // ==========================================================
  // state
  typedef struct packed {
    eng_e                         eng;
    logic [2:0]                   slot;
    logic                         dir_in;
    logic [2:0]                   ld_idx;
    logic [5:0][REG_W-1:0]        ctx;
    logic [PTR_W-1:0]             ptr;
    logic [PTR_W-1:0]             cnt;
    logic                         half;
    logic [7:0]                   lo;
    logic                         collide;
    logic                         pend;
    mem_word_s                    pend_w;
    logic [DATA_W-1:0]            word;
    logic                         rd_sent;
    logic [EP_COUNT-1:0][4:0]     setup;
    logic [EP_COUNT-1:0][3:0]     naks;
    logic                         dsp_rd;
    logic [15:0]                  det_cnt;
    logic                         reg_ack;
    logic [REG_W-1:0]             reg_rdata;
    logic                         attach;
    logic                         config_only;
    logic                         tok_ready;
    logic                         rx_ready;
    logic                         tx_valid;
    logic [7:0]                   tx_byte;
    logic                         tx_last;
    logic                         tx_empty;
    logic                         hs_ack;
    logic                         hs_nak;
    logic                         mem_req;
    logic                         mem_we;
    logic [ADDR_W-1:0]            mem_addr;
    logic [DATA_W-1:0]            mem_wdata;
  } st_s;

  st_s s, n;

  logic             mwr_en;
  logic [5:0]       mwr_addr;
  logic [REG_W-1:0] mwr_data;
  logic             mrd_en;
  logic [5:0]       mrd_addr;
  logic [REG_W-1:0] mrd_data;
  logic             fin_valid;
  logic             fin_ready;
  logic             fout_valid;
  logic             fout_ready;
  mem_word_s        fout_data;

  // ==========================================================
  // helpers
  function automatic logic [PTR_W-1:0] wrap_inc(
    input logic [PTR_W-1:0] p, input logic [PTR_W-1:0] size);
    logic [PTR_W-1:0] q;
    q = p + 1'b1;
    wrap_inc = (q == size) ? '0 : q;
  endfunction : wrap_inc

  function automatic logic [PTR_W-1:0] ring_diff(
    input logic [PTR_W-1:0] a, input logic [PTR_W-1:0] b,
    input logic [PTR_W-1:0] size);
    ring_diff = (a >= b) ? a - b : a + size - b;
  endfunction : ring_diff

  function automatic logic [ADDR_W-1:0] buf_addr(
    input logic [REG_W-1:0] base, input logic [PTR_W-1:0] p);
    // software keeps the sum inside the 18-bit space
    buf_addr = base + {2'h0, p};
  endfunction : buf_addr

  // ==========================================================
  // submodules
  ep_store #(
    .WIDTH (REG_W),
    .AW    (6)
  ) u_store (
    .clock   (clock),
    .wr_en   (mwr_en),
    .wr_addr (mwr_addr),
    .wr_data (mwr_data),
    .rd_en   (mrd_en),
    .rd_addr (mrd_addr),
    .rd_data (mrd_data)
  );

  word_fifo #(
    .WIDTH ($bits(mem_word_s)),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clock     (clock),
    .rst       (rst),
    .in_valid  (fin_valid),
    .in_ready  (fin_ready),
    .in_data   (s.pend_w),
    .out_valid (fout_valid),
    .out_ready (fout_ready),
    .out_data  (fout_data)
  );

  assign fin_valid = s.pend;
  assign fout_ready = !s.mem_req || mem_gnt;

  // ==========================================================
  // next state
  logic [2:0]       r_slot;
  logic [2:0]       r_fld;
  logic             dsp_ok;
  logic [PTR_W-1:0] size;
  logic [PTR_W-1:0] rd_off;
  logic [PTR_W-1:0] wr_off;
  logic [PTR_W-1:0] avail;
  logic [PTR_W-1:0] mpw;
  logic [PTR_W-1:0] nxt_ptr;

  always_comb begin
    n = s;
    mwr_en = 1'b0;
    mwr_addr = '0;
    mwr_data = '0;
    mrd_en = 1'b0;
    mrd_addr = '0;
    r_slot = reg_addr[5:3];
    r_fld = reg_addr[2:0];
    size = s.ctx[F_SIZE][PTR_W-1:0];
    rd_off = s.ctx[F_RDOFF][PTR_W-1:0];
    wr_off = s.ctx[F_WROFF][PTR_W-1:0];
    avail = ring_diff(wr_off, rd_off, size);
    mpw = PTR_W'(s.ctx[F_DESC][DESC_MPS_LSB +: DESC_MPS_W] >> 1);
    nxt_ptr = wrap_inc(s.ptr, size);
    n.hs_ack = 1'b0;
    n.hs_nak = 1'b0;
    n.reg_ack = 1'b0;
    n.dsp_rd = 1'b0;

    // memory master: fifo drains words, back-pressured by grant
    if (fin_valid && fin_ready) begin
      n.pend = 1'b0;
    end
    if (s.mem_req && mem_gnt) begin
      n.mem_req = 1'b0;
    end
    if (fout_valid && fout_ready) begin
      n.mem_req = 1'b1;
      n.mem_we = 1'b1;
      n.mem_addr = fout_data.addr;
      n.mem_wdata = fout_data.data;
    end

    // reattach countdown
    if (s.det_cnt != '0) begin
      n.det_cnt = s.det_cnt - 1'b1;
      if (s.det_cnt == 16'h0001) begin
        n.attach = 1'b1;
        n.config_only = 1'b0;
      end
    end

    // dsp registers; engine owns the store while loading
    dsp_ok = reg_req && !s.reg_ack && !s.dsp_rd &&
             (s.eng != ST_LOAD) && (s.eng != ST_WBACK);
    if (s.dsp_rd) begin
      n.reg_ack = 1'b1;
      n.reg_rdata = mrd_data;
    end else if (dsp_ok) begin
      n.reg_ack = 1'b1;
      n.reg_rdata = '0;
      if (r_fld == F_CTRL) begin
        if (reg_we && r_slot == 3'h0 &&
            reg_wdata[CTRL_RECONNECT_BIT]) begin
          n.attach = 1'b0;
          n.det_cnt = 16'(DETACH_CYC);
        end
      end else if (r_fld == F_STAT) begin
        if (r_slot == 3'h0) begin
          n.reg_rdata = {8'h00, s.tok_ready, s.config_only,
                         s.attach, 7'h00};
        end
      end else if (reg_we) begin
        mwr_en = 1'b1;
        mwr_addr = reg_addr;
        mwr_data = reg_wdata;
        if (r_fld <= F_WROFF) begin
          n.setup[r_slot][r_fld] = 1'b1;
        end
      end else begin
        n.reg_ack = 1'b0;
        n.dsp_rd = 1'b1;
        mrd_en = 1'b1;
        mrd_addr = reg_addr;
      end
    end

    // ========================================================
    // engine
    case (s.eng)
      ST_IDLE: begin
        // other endpoints, ep0 bytes included, go elsewhere
        if (tok_valid && s.tok_ready && !s.config_only &&
            tok_ep >= EP_FIRST && tok_ep <= EP_LAST) begin
          n.slot = 3'(tok_ep - EP_FIRST);
          n.dir_in = tok_in;
          n.ld_idx = '0;
          n.eng = ST_LOAD;
        end
      end
      ST_LOAD: begin
        if (s.ld_idx != 3'h6) begin
          mrd_en = 1'b1;
          mrd_addr = {s.slot, s.ld_idx};
        end
        if (s.ld_idx != 3'h0) begin
          n.ctx[s.ld_idx - 1'b1] = mrd_data;
        end
        n.ld_idx = s.ld_idx + 1'b1;
        if (s.ld_idx == 3'h6) begin
          n.eng = ST_DECIDE;
        end
      end
      ST_DECIDE: begin
        if (s.setup[s.slot] != SETUP_ALL ||
            s.ctx[F_DESC][DESC_DIR_BIT] != s.dir_in) begin
          n.hs_nak = 1'b1;
          n.eng = ST_IDLE;
        end else if (!s.dir_in) begin
          n.ptr = wr_off;
          n.collide = 1'b0;
          n.half = 1'b0;
          n.eng = ST_OUT_RX;
        end else if (avail >= mpw ||
                     s.naks[s.slot] ==
                     s.ctx[F_POLICY][NAK_LIMIT_W-1:0]) begin
          n.cnt = (avail >= mpw) ? mpw : avail;
          n.ptr = rd_off;
          n.rd_sent = 1'b0;
          if (n.cnt == '0) begin
            n.tx_valid = 1'b1;
            n.tx_last = 1'b1;
            n.tx_empty = 1'b1;
            n.eng = ST_IN_HI;
          end else begin
            n.eng = ST_IN_RD;
          end
        end else begin
          n.naks[s.slot] = s.naks[s.slot] + 1'b1;
          n.hs_nak = 1'b1;
          n.eng = ST_IDLE;
        end
      end
      ST_OUT_RX: begin
        // no length cap: oversize packets pass while room lasts
        if (rx_valid && s.rx_ready) begin
          if (!s.half) begin
            n.lo = rx_byte;
            n.half = 1'b1;
          end else begin
            n.half = 1'b0;
            if (!s.collide) begin
              if (nxt_ptr == rd_off) begin
                n.collide = 1'b1;
              end else begin
                n.pend = 1'b1;
                n.pend_w.addr = buf_addr(s.ctx[F_BASE], s.ptr);
                n.pend_w.data = {rx_byte, s.lo};
                n.ptr = nxt_ptr;
              end
            end
          end
          // a trailing odd byte never reaches memory
          if (rx_last) begin
            n.eng = ST_OUT_DRAIN;
          end
        end
      end
      ST_OUT_DRAIN: begin
        if (!s.pend && !fout_valid && !s.mem_req) begin
          if (s.collide) begin
            n.hs_nak = 1'b1;
            n.eng = ST_IDLE;
          end else begin
            n.hs_ack = 1'b1;
            n.eng = ST_WBACK;
          end
        end
      end
      ST_WBACK: begin
        // only the pointer this side owns is written back
        mwr_en = 1'b1;
        mwr_addr = {s.slot, s.dir_in ? F_RDOFF : F_WROFF};
        mwr_data = {2'h0, s.ptr};
        n.eng = ST_IDLE;
      end
      ST_IN_RD: begin
        if (!s.rd_sent) begin
          n.mem_req = 1'b1;
          n.mem_we = 1'b0;
          n.mem_addr = buf_addr(s.ctx[F_BASE], s.ptr);
          n.rd_sent = 1'b1;
        end else if (mem_rvalid) begin
          n.word = mem_rdata;
          n.rd_sent = 1'b0;
          n.tx_valid = 1'b1;
          n.tx_byte = mem_rdata[7:0];
          n.tx_last = 1'b0;
          n.eng = ST_IN_LO;
        end
      end
      ST_IN_LO: begin
        if (tx_ready) begin
          n.tx_byte = s.word[15:8];
          n.tx_last = (s.cnt == 16'h0001);
          n.eng = ST_IN_HI;
        end
      end
      ST_IN_HI: begin
        if (tx_ready) begin
          n.tx_valid = 1'b0;
          n.tx_last = 1'b0;
          n.tx_empty = 1'b0;
          if (s.tx_empty) begin
            n.eng = ST_IN_WAIT;
          end else begin
            n.ptr = nxt_ptr;
            n.cnt = s.cnt - 1'b1;
            n.eng = (s.cnt == 16'h0001) ? ST_IN_WAIT : ST_IN_RD;
          end
        end
      end
      ST_IN_WAIT: begin
        // a non-ACK handshake leaves the read offset for a retry
        if (in_hs_valid) begin
          if (in_hs_ack) begin
            n.naks[s.slot] = '0;
            n.eng = ST_WBACK;
          end else begin
            n.eng = ST_IDLE;
          end
        end
      end
      default: begin
        n.eng = ST_IDLE;
      end
    endcase

    n.tok_ready = (n.eng == ST_IDLE);
    n.rx_ready = (n.eng == ST_OUT_RX) && !n.pend;
  end

  // ==========================================================
  // registers
  always_ff @(posedge clock) begin
    if (rst) begin
      s <= '0;
      s.eng <= ST_IDLE;
      s.attach <= 1'b1;
      s.config_only <= 1'b1;
      s.tok_ready <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign reg_ack_r = s.reg_ack;
  assign reg_rdata_r = s.reg_rdata;
  assign attach_r = s.attach;
  assign config_only_r = s.config_only;
  assign tok_ready_r = s.tok_ready;
  assign rx_ready_r = s.rx_ready;
  assign tx_valid_r = s.tx_valid;
  assign tx_byte_r = s.tx_byte;
  assign tx_last_r = s.tx_last;
  assign tx_empty_r = s.tx_empty;
  assign hs_ack_r = s.hs_ack;
  assign hs_nak_r = s.hs_nak;
  assign mem_req_r = s.mem_req;
  assign mem_we_r = s.mem_we;
  assign mem_addr_r = s.mem_addr;
  assign mem_wdata_r = s.mem_wdata;
endmodule : ring_engine

//--- bench/ring_monitor.sv
`timescale 1ns/1ps
module ring_monitor import ring_pkg::*; (
  // clock and reset
  input wire logic              clock,
  input wire logic              rst,
  // register port
  input wire logic              reg_req,
  input wire logic              reg_we,
  input wire logic [5:0]        reg_addr,
  input wire logic [REG_W-1:0]  reg_wdata,
  input wire logic              reg_ack_r,
  // attachment
  input wire logic              attach_r,
  input wire logic              config_only_r,
  // link side
  input wire logic              tok_valid,
  input wire logic [3:0]        tok_ep,
  input wire logic              tok_ready_r,
  input wire logic              tx_valid_r,
  input wire logic [7:0]        tx_byte_r,
  input wire logic              tx_ready,
  input wire logic              hs_ack_r,
  input wire logic              hs_nak_r,
  // memory side
  input wire logic              mem_req_r,
  input wire logic              mem_we_r,
  input wire logic [ADDR_W-1:0] mem_addr_r,
  input wire logic              mem_gnt
);
  // ============
  // detach length counter
  logic [9:0] low_r;
  always_ff @(posedge clock) begin
    if (rst || attach_r) low_r <= '0;
    else low_r <= low_r + 10'h001;
  end

  // ============
  // properties
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_ctrl_wr;
    reg_req && reg_we && reg_addr == {3'h0, F_CTRL}
      && reg_wdata[CTRL_RECONNECT_BIT] ##1 reg_ack_r;
  endsequence
  sequence s_reattach;
    $rose(attach_r);
  endsequence

  a_ack_pulse: assert property (reg_ack_r |=> !reg_ack_r)
    else $error("ack too long");
  a_ack_bound: assert property ($rose(reg_req) |-> ##[1:24] reg_ack_r)
    else $error("no ack");
  a_ctrl_detach: assert property (s_ctrl_wr |-> ##[0:4] !attach_r)
    else $error("no detach");
  a_detach_len: assert property (s_reattach |->
    low_r >= 10'(DETACH_CYC - 1) && low_r <= 10'(DETACH_CYC + 1))
    else $error("detach time wrong");
  a_reattach_cfg: assert property (s_reattach |-> ##[0:1] !config_only_r)
    else $error("still control-only");
  a_cfg_silent: assert property (config_only_r |->
    !hs_ack_r && !hs_nak_r && !tx_valid_r)
    else $error("traffic while control-only");
  a_hs_excl: assert property (!(hs_ack_r && hs_nak_r))
    else $error("ack and nak together");
  a_mem_hold: assert property (mem_req_r && !mem_gnt |=>
    mem_req_r && $stable(mem_addr_r) && $stable(mem_we_r))
    else $error("mem request changed");
  a_tok_taken: assert property (tok_valid && tok_ready_r && !config_only_r
    && tok_ep >= EP_FIRST && tok_ep <= EP_LAST |-> ##[1:2] !tok_ready_r)
    else $error("token not taken");
  a_tx_hold: assert property (tx_valid_r && !tx_ready |=>
    tx_valid_r && $stable(tx_byte_r))
    else $error("tx byte dropped");
endmodule : ring_monitor

bind ring_engine ring_monitor u_mon (.*);

//--- bench/dsp_mem_model.sv
`timescale 1ns/1ps
module dsp_mem_model import ring_pkg::*; (
  // clock and reset
  input  wire logic              clock,
  input  wire logic              rst,
  // stall control
  input  wire logic              slow,
  // memory port
  input  wire logic              mem_req,
  input  wire logic              mem_we,
  input  wire logic [ADDR_W-1:0] mem_addr,
  input  wire logic [DATA_W-1:0] mem_wdata,
  output logic                   mem_gnt,
  output logic                   mem_rvalid,
  output logic      [DATA_W-1:0] mem_rdata
);
  logic [DATA_W-1:0] store [logic [ADDR_W-1:0]];
  logic              pend_r;
  logic [DATA_W-1:0] hold_r;
  initial mem_rdata = 16'h5A5A;
  // idle data toggles so stale samples never look valid
  always @(posedge clock) begin
    mem_gnt <= 1'b0;
    mem_rvalid <= pend_r;
    mem_rdata <= pend_r ? hold_r : ~mem_rdata;
    pend_r <= 1'b0;
    if (!rst && mem_req && !mem_gnt && (!slow || $urandom_range(1, 0))) begin
      mem_gnt <= 1'b1;
      if (mem_we) store[mem_addr] = mem_wdata;
      else begin
        pend_r <= 1'b1;
        hold_r <= store.exists(mem_addr) ? store[mem_addr] : ~mem_addr[15:0];
      end
    end
  end
endmodule : dsp_mem_model

//--- bench/tb_usb_endpoint_ring_buffer_dma.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
  err_total++; $display("Error %s exp %0h got %0h", n, e, g); end end
module tb_usb_endpoint_ring_buffer_dma import ring_pkg::*;;
  logic clock, rst, reg_req, reg_we, tok_valid, tok_in, rx_valid, rx_last;
  logic tx_ready, in_hs_valid, in_hs_ack, slow, reg_ack_r, attach_r;
  logic config_only_r, tok_ready_r, rx_ready_r, tx_valid_r, tx_last_r;
  logic tx_empty_r, hs_ack_r, hs_nak_r, mem_req_r, mem_we_r, mem_gnt;
  logic              mem_rvalid;
  logic [5:0]        reg_addr;
  logic [3:0]        tok_ep;
  logic [7:0]        rx_byte, tx_byte_r;
  logic [7:0]        pk [16];
  logic [7:0]        ib [16];
  logic [REG_W-1:0]  reg_wdata, reg_rdata_r, rd;
  logic [REG_W-1:0]  fv [6];
  logic [ADDR_W-1:0] mem_addr_r, a;
  logic [DATA_W-1:0] mem_wdata_r, mem_rdata, d;
  int                err_total, comparisons, cyc, acks, naks;

  ring_engine #(.DEPTH(FIFO_DEPTH)) DUT (.*);
  dsp_mem_model u_mem (.clock, .rst, .slow, .mem_req(mem_req_r),
    .mem_we(mem_we_r), .mem_addr(mem_addr_r), .mem_wdata(mem_wdata_r),
    .mem_gnt, .mem_rvalid, .mem_rdata);

  // ============
  // clock, tally, timeout
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc++;
    if (hs_ack_r === 1'b1) acks++;
    if (hs_nak_r === 1'b1) naks++;
    if (cyc == 20000) begin
      err_total++;
      wrap_up();
    end
  end

  // ============
  // helpers
  function automatic int room(int w, int r);
    return (r - w + 15) % 16;
  endfunction : room

  task automatic wrap_up();
    if (err_total == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : wrap_up

  task automatic reg_io(input logic we, input logic [5:0] ad,
                        input logic [REG_W-1:0] wd);
    int n;
    @(negedge clock);
    reg_req = 1'b1; reg_we = we; reg_addr = ad; reg_wdata = wd;
    n = 0;
    do begin @(negedge clock); n++; end while (reg_ack_r !== 1'b1 && n < 40);
    rd = reg_rdata_r;
    reg_req = 1'b0;
  endtask : reg_io

  // res: 0 none, 1 ack, 2 nak
  task automatic out_pkt(input logic [3:0] ep, input int n, output int res);
    int a0, n0, k, t;
    a0 = acks; n0 = naks;
    @(negedge clock);
    tok_valid = 1'b1; tok_ep = ep; tok_in = 1'b0;
    @(negedge clock);
    tok_valid = 1'b0;
    t = 0;
    while (rx_ready_r !== 1'b1 && naks == n0 && t < 20) begin
      @(negedge clock); t++;
    end
    if (rx_ready_r === 1'b1)
      for (k = 0; k < n; k++) begin
        rx_valid = 1'b1; rx_byte = pk[k]; rx_last = (k == n - 1);
        t = 0;
        do begin @(posedge clock); t++; end
          while (rx_ready_r !== 1'b1 && t < 40);
        @(negedge clock);
      end
    rx_valid = 1'b0; rx_last = 1'b0;
    t = 0;
    while (acks + naks == a0 + n0 && t < 100) begin
      @(negedge clock); t++;
    end
    res = (acks > a0) ? 1 : (naks > n0) ? 2 : 0;
  endtask : out_pkt

  task automatic in_pkt(input logic ok, output int nb, output logic nk);
    int t;
    nb = 0; nk = 1'b0;
    @(negedge clock);
    tok_valid = 1'b1; tok_ep = 4'h6; tok_in = 1'b1;
    @(negedge clock);
    tok_valid = 1'b0;
    for (t = 0; t < 150; t++) begin
      @(posedge clock);
      if (hs_nak_r === 1'b1) begin nk = 1'b1; break; end
      if (tx_valid_r === 1'b1 && tx_ready) begin
        if (tx_empty_r !== 1'b1) begin ib[nb] = tx_byte_r; nb++; end
        if (tx_last_r === 1'b1) break;
      end
      @(negedge clock);
      tx_ready = 1'($urandom_range(1, 0));
    end
    @(negedge clock);
    if (!nk) begin
      in_hs_valid = 1'b1; in_hs_ack = ok;
      @(negedge clock);
      in_hs_valid = 1'b0;
    end
  endtask : in_pkt

  // ============
  // main sequence
  initial begin
    int i, k, n, res, w, r, av, cnt, nb;
    logic nk;
    void'($urandom(32'h7916));
    {reg_req, reg_we, tok_valid, tok_in, rx_valid, rx_last} = '0;
    {in_hs_valid, in_hs_ack, slow, reg_addr, tok_ep, rx_byte} = '0;
    reg_wdata = '0; tx_ready = 1'b1; rst = 1'b1;
    repeat (8) @(negedge clock);
    rst = 1'b0;
    reg_io(1'b0, {3'h0, F_STAT}, '0);
    `CHK("status", 18'h00380, rd)
    out_pkt(4'h4, 2, res);
    `CHK("cfg_only_hs", 0, res)
    reg_io(1'b1, {3'h0, F_CTRL}, 18'h00001);
    k = 0;
    while (attach_r !== 1'b1 && k < 700) begin @(negedge clock); k++; end
    `CHK("reattach", 1'b0, config_only_r)
    for (i = 0; i < 2; i++) begin
      out_pkt(i ? 4'hC : 4'h3, 2, res);
      `CHK("ep_range", 0, res)
    end
    // buffer ends at the top address
    fv = '{18'h00040, 18'h3FFF0, 18'h00010, 18'h0, 18'h0, 18'h0};
    for (i = 0; i < 4; i++) reg_io(1'b1, {3'h1, i[2:0]}, fv[i]);
    out_pkt(4'h5, 2, res);
    `CHK("partial_setup", 2, res)
    reg_io(1'b1, {3'h1, F_WROFF}, 18'h0);
    for (i = 1; i < 5; i++) begin
      reg_io(1'b0, {3'h1, i[2:0]}, '0);
      `CHK("field", fv[i], rd)
    end
    w = 0; r = 0;
    for (i = 0; i < 12; i++) begin
      slow = (i >= 6);
      n = (i == 2) ? 3 : (i == 4) ? 12 : 2 * $urandom_range(4, 1);
      for (k = 0; k < n; k++) pk[k] = 8'($urandom);
      out_pkt(4'h5, n, res);
      `CHK("out_hs", (n / 2 <= room(w, r)) ? 1 : 2, res)
      if (res == 1) begin
        for (k = 0; k < n / 2; k++) begin
          a = ADDR_W'(32'h3FFF0 + (w + k) % 16);
          `CHK("out_mem", {pk[2*k+1], pk[2*k]}, u_mem.store[a])
        end
        w = (w + n / 2) % 16;
      end
      reg_io(1'b0, {3'h1, F_WROFF}, '0);
      `CHK("wr_off", 18'(w), rd)
      if (i % 4 == 3) begin
        r = w;
        reg_io(1'b1, {3'h1, F_RDOFF}, 18'(r));
      end
    end
    fv = '{18'h00041, 18'h01000, 18'h00010, 18'h0, 18'h00006, 18'h00002};
    for (i = 0; i < 6; i++) reg_io(1'b1, {3'h2, i[2:0]}, fv[i]);
    for (k = 0; k < 16; k++) u_mem.store[ADDR_W'(32'h1000 + k)] = 16'($urandom);
    r = 0; w = 6; cnt = 0;
    for (i = 0; i < 8; i++) begin
      av = (w - r + 16) % 16;
      n = (av >= 4) ? 4 : (cnt == 2) ? av : -1;
      in_pkt(i != 0, nb, nk);
      `CHK("in_nak", n < 0, nk)
      cnt = (n < 0) ? cnt + 1 : (i != 0) ? 0 : cnt;
      if (n >= 0) begin
        `CHK("in_len", 2 * n, nb)
        for (k = 0; k < 2 * n; k++) begin
          d = u_mem.store[ADDR_W'(32'h1000 + (r + k / 2) % 16)];
          `CHK("in_byte", (k % 2) ? d[15:8] : d[7:0], ib[k])
        end
        if (i != 0) r = (r + n) % 16;
      end
      reg_io(1'b0, {3'h2, F_RDOFF}, '0);
      `CHK("rd_off", 18'(r), rd)
    end
    wrap_up();
  end
endmodule : tb_usb_endpoint_ring_buffer_dma
